// ==== src/compact_timer.sv ====
// Compact 10-bit timer with AXI4-Lite register access
`include "timer_params.svh"

module compact_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic external_clock_pin,
  output logic timer_output,
  output logic compare_match_flag,
  output logic period_match_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    timer_pkg::ctrl0_s ctrl0;
    timer_pkg::ctrl1_s ctrl1;
    logic [9:0] count;
    logic [9:0] compare_value;
    logic [7:0] low_buffer;
    logic enable_prev;
    logic cmp_flag;
    logic per_flag;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } st_s;

  st_s st_r;
  st_s st_nxt;
  logic tick;
  logic enable_rise;
  logic run_tick;
  logic cmp_hit;
  logic per_hit;
  logic overflow;
  logic clear_now;
  logic cmp_event;
  logic per_event;
  logic pwm_active;
  logic [10:0] period_len;
  logic [10:0] duty_len;

  // Period length in timer clocks; code zero means the full 1024
  function automatic logic [10:0] period_of(input logic [2:0] code);
    period_of = (code == 3'h0) ? `PERIOD_FULL : {1'b0, code, 7'h00};
  endfunction : period_of

  function automatic logic is_offset(input logic [7:0] a, input logic [7:0] off);
    is_offset = (a[7:2] == off[7:2]);
  endfunction : is_offset

  // ----------------------------------------------------------------
  // Timer clock
  // ----------------------------------------------------------------
  clock_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_select(st_r.ctrl0.clock_select),
    .high_clock_tick(high_clock_tick),
    .sub_clock_tick(sub_clock_tick),
    .external_clock_pin(external_clock_pin),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Counter and comparators
  // ----------------------------------------------------------------
  assign enable_rise = st_r.ctrl0.enable & ~st_r.enable_prev;
  assign run_tick = tick & st_r.ctrl0.enable & ~st_r.ctrl0.pause;
  // Comparators look at the value about to be reached by this tick
  logic [9:0] count_inc;
  assign count_inc = st_r.count + 10'h001;
  assign per_hit = run_tick && (st_r.ctrl0.period_setting != 3'h0) &&
                   (count_inc[9:`PER_LSB] == st_r.ctrl0.period_setting) &&
                   (count_inc[`PER_LSB-1:0] == 7'h00);
  assign cmp_hit = run_tick && (st_r.compare_value != 10'h000) &&
                   (count_inc == st_r.compare_value);
  assign overflow = run_tick && (st_r.count == `CNT_MAX);
  assign period_len = period_of(st_r.ctrl0.period_setting);
  assign duty_len = {1'b0, st_r.compare_value};

  always_comb begin
    logic pwm;
    logic swap;
    pwm = (st_r.ctrl1.mode_field == timer_pkg::mode_pwm);
    swap = st_r.ctrl1.period_duty_swap;
    per_event = 1'b0;
    cmp_event = 1'b0;
    clear_now = 1'b0;
    if (pwm) begin
      // Clear comes from whichever register sets the period
      per_event = per_hit || (overflow && st_r.ctrl0.period_setting == 3'h0);
      cmp_event = cmp_hit;
      clear_now = swap ? cmp_hit : per_event;
    end else if (st_r.ctrl1.clear_select) begin
      cmp_event = cmp_hit;
      clear_now = cmp_hit || overflow;
    end else begin
      per_event = per_hit || (overflow && st_r.ctrl0.period_setting == 3'h0);
      cmp_event = cmp_hit;
      clear_now = per_hit || overflow;
    end
    if (!swap) begin
      pwm_active = ({1'b0, st_r.count} < duty_len) || (duty_len >= period_len);
    end else begin
      pwm_active = ({1'b0, st_r.count} < period_len) ||
                   (period_len >= duty_len && st_r.compare_value != 10'h000);
    end
  end

  // ----------------------------------------------------------------
  // Bus slave and register next state
  // ----------------------------------------------------------------
  assign s_axi_awready = ~st_r.aw_held & ~st_r.bvalid;
  assign s_axi_wready = ~st_r.w_held & ~st_r.bvalid;
  assign s_axi_arready = ~st_r.rvalid;

  always_comb begin
    logic [7:0] wb;
    logic [7:0] rb;
    logic do_wr;
    wb = 8'h00;
    rb = 8'h00;
    do_wr = 1'b0;
    st_nxt = st_r;
    st_nxt.enable_prev = st_r.ctrl0.enable;

    if (enable_rise) begin
      st_nxt.count = 10'h000;
    end else if (run_tick) begin
      st_nxt.count = clear_now ? 10'h000 : count_inc;
    end
    // Flags are sticky until software writes a one; the set wins
    if (cmp_event) st_nxt.cmp_flag = 1'b1;
    if (per_event) st_nxt.per_flag = 1'b1;

    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    do_wr = st_r.aw_held && st_r.w_held;
    wb = st_r.w_data[7:0];
    if (do_wr) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `RESP_OKAY;
      if (st_r.w_strb[0]) begin
        if (is_offset(st_r.aw_addr, `OFF_CTRL0)) begin
          st_nxt.ctrl0 = timer_pkg::ctrl0_s'(wb);
        end else if (is_offset(st_r.aw_addr, `OFF_CTRL1)) begin
          st_nxt.ctrl1 = timer_pkg::ctrl1_s'(wb);
        end else if (is_offset(st_r.aw_addr, `OFF_CMP_LO)) begin
          st_nxt.low_buffer = wb;
        end else if (is_offset(st_r.aw_addr, `OFF_CMP_HI)) begin
          st_nxt.compare_value = {wb[1:0], st_r.low_buffer};
        end else if (is_offset(st_r.aw_addr, `OFF_FLAGS)) begin
          if (wb[0] && !cmp_event) st_nxt.cmp_flag = 1'b0;
          if (wb[1] && !per_event) st_nxt.per_flag = 1'b0;
        end else if (!is_offset(st_r.aw_addr, `OFF_CNT_LO) &&
                     !is_offset(st_r.aw_addr, `OFF_CNT_HI)) begin
          st_nxt.bresp = `RESP_SLVERR;
        end
      end
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;

    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `RESP_OKAY;
      if (is_offset(s_axi_araddr, `OFF_CTRL0)) begin
        rb = st_r.ctrl0;
      end else if (is_offset(s_axi_araddr, `OFF_CTRL1)) begin
        rb = st_r.ctrl1;
      end else if (is_offset(s_axi_araddr, `OFF_CNT_LO) ||
                   is_offset(s_axi_araddr, `OFF_CMP_LO)) begin
        rb = st_r.low_buffer;
      end else if (is_offset(s_axi_araddr, `OFF_CNT_HI)) begin
        rb = {6'h00, st_r.count[9:8]};
        st_nxt.low_buffer = st_r.count[7:0];
      end else if (is_offset(s_axi_araddr, `OFF_CMP_HI)) begin
        rb = {6'h00, st_r.compare_value[9:8]};
        st_nxt.low_buffer = st_r.compare_value[7:0];
      end else if (is_offset(s_axi_araddr, `OFF_FLAGS)) begin
        rb = {6'h00, st_r.per_flag, st_r.cmp_flag};
      end else begin
        st_nxt.rresp = `RESP_SLVERR;
      end
      st_nxt.rdata = {24'h000000, rb};
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign compare_match_flag = st_r.cmp_flag;
  assign period_match_flag = st_r.per_flag;

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  timer_output_unit u_out (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode_field(st_r.ctrl1.mode_field),
    .output_function(st_r.ctrl1.output_function),
    .output_control(st_r.ctrl1.output_control),
    .output_polarity(st_r.ctrl1.output_polarity),
    .enable_rise(enable_rise && st_r.ctrl1.mode_field == timer_pkg::mode_compare),
    .compare_event(cmp_event && st_r.ctrl1.mode_field == timer_pkg::mode_compare),
    .pwm_active(pwm_active),
    .timer_output(timer_output)
  );

endmodule : compact_timer

// ==== common/timer_params.svh ====
// Constants and register map for the compact timer
// Behaviour
// - 10-bit up-counter advances per timer clock
// - Period compares bits 9:7, compare all bits
// - No counter write; enable rise clears counter
// - Pause holds count; resume from held value
// - Clock select picks one of seven sources
// - Reserved clock code freezes the counter
// - Enable off stops counter, keeps value
// - Enable rise forces initial output level in compare mode
// - Period is multiples of 128; zero gives 1024
// - Clear-select 0: period match or overflow clears
// - Clear-select 1: compare match clears counter
// - PWM ignores clear-select; swap bit decides roles
// - Mode field: 00 compare, 10 PWM, 11 timer
// - Compare match drives output per function field
// - Match to current level shows no change
// - PWM function: inactive, active, waveform
// - Output control gives initial or active level
// - Polarity bit inverts output except timer mode
// - Swap bit exchanges period and duty roles
// - Counter and compare exposed as byte pairs
// - Low bytes pass through shared byte buffer
// - Clear-select 1 suppresses period match flag
// - Zero compare overflows without compare flag
// - Duty at or above period gives full active
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define CNT_W 10
`define CNT_MAX 10'h3ff
`define PER_LSB 7
// Period code zero runs the full counter range
`define PERIOD_FULL 11'h400

`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_CNT_LO 8'h08
`define OFF_CNT_HI 8'h0c
`define OFF_CMP_LO 8'h10
`define OFF_CMP_HI 8'h14
`define OFF_FLAGS 8'h18

`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00

`define CK_SYS_DIV4 3'h0
`define CK_SYS 3'h1
`define CK_HIGH_DIV16 3'h2
`define CK_HIGH_DIV64 3'h3
`define CK_SUB 3'h4
`define CK_EXT_RISE 3'h6
`define CK_EXT_FALL 3'h7

`define DIV4_TOP 6'h03
`define DIV16_TOP 6'h0f
`define DIV64_TOP 6'h3f

`define IO_NONE 2'h0
`define IO_LOW 2'h1
`define IO_HIGH 2'h2
`define IO_TOGGLE 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== common/timer_pkg.sv ====
// Types shared by the compact timer files
package timer_pkg;

  typedef enum logic [1:0] {
    mode_compare = 2'h0,
    mode_undef = 2'h1,
    mode_pwm = 2'h2,
    mode_timer = 2'h3
  } mode_e;

  typedef struct packed {
    logic pause;
    logic [2:0] clock_select;
    logic enable;
    logic [2:0] period_setting;
  } ctrl0_s;

  typedef struct packed {
    logic [1:0] mode_field;
    logic [1:0] output_function;
    logic output_control;
    logic output_polarity;
    logic period_duty_swap;
    logic clear_select;
  } ctrl1_s;

endpackage : timer_pkg

// ==== src/clock_tick_gen.sv ====
// Timer clock tick selection: prescalers, pin synchroniser, edge detect
`include "timer_params.svh"

module clock_tick_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] clock_select,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic external_clock_pin,
  output logic tick
);

  typedef struct packed {
    logic [5:0] sys_div;
    logic [5:0] high_div;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
  } st_s;

  st_s st_r;
  st_s st_nxt;
  logic ext_rise;
  logic ext_fall;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sys_div = (st_r.sys_div == `DIV4_TOP) ? 6'h00 : st_r.sys_div + 6'h01;
    if (high_clock_tick) begin
      st_nxt.high_div = st_r.high_div + 6'h01;
    end
    // Second stage alone feeds the edge detector
    st_nxt.ext_meta = external_clock_pin;
    st_nxt.ext_sync = st_r.ext_meta;
    st_nxt.ext_prev = st_r.ext_sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ext_rise = st_r.ext_sync & ~st_r.ext_prev;
  assign ext_fall = ~st_r.ext_sync & st_r.ext_prev;

  always_comb begin
    case (clock_select)
      `CK_SYS_DIV4: tick = (st_r.sys_div == `DIV4_TOP);
      `CK_SYS: tick = 1'b1;
      `CK_HIGH_DIV16: tick = high_clock_tick && ((st_r.high_div & `DIV16_TOP) == `DIV16_TOP);
      `CK_HIGH_DIV64: tick = high_clock_tick && (st_r.high_div == `DIV64_TOP);
      `CK_SUB: tick = sub_clock_tick;
      `CK_EXT_RISE: tick = ext_rise;
      `CK_EXT_FALL: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

endmodule : clock_tick_gen

// ==== src/timer_output_unit.sv ====
// Output pin logic for compare-match and PWM modes
`include "timer_params.svh"

module timer_output_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode_field,
  input wire logic [1:0] output_function,
  input wire logic output_control,
  input wire logic output_polarity,
  input wire logic enable_rise,
  input wire logic compare_event,
  input wire logic pwm_active,
  output logic timer_output
);

  typedef struct packed {
    logic level;
    logic pin;
  } st_s;

  st_s st_r;
  st_s st_nxt;
  logic raw;

  always_comb begin
    st_nxt = st_r;
    if (enable_rise) begin
      st_nxt.level = output_control;
    end else if (compare_event) begin
      case (output_function)
        `IO_LOW: st_nxt.level = 1'b0;
        `IO_HIGH: st_nxt.level = 1'b1;
        `IO_TOGGLE: st_nxt.level = ~st_r.level;
        default: st_nxt.level = st_r.level;
      endcase
    end
    case (timer_pkg::mode_e'(mode_field))
      timer_pkg::mode_pwm: begin
        case (output_function)
          `IO_LOW: raw = output_control;
          `IO_HIGH: raw = pwm_active ? output_control : ~output_control;
          default: raw = ~output_control;
        endcase
        // Codes 00 and 11 both rest inactive; 01 is active
        if (output_function == `IO_LOW) raw = output_control;
        else if (output_function == `IO_NONE) raw = ~output_control;
      end
      timer_pkg::mode_compare: raw = st_r.level;
      default: raw = 1'b0;
    endcase
    if (mode_field == timer_pkg::mode_timer) begin
      st_nxt.pin = 1'b0;
    end else begin
      st_nxt.pin = raw ^ output_polarity;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timer_output = st_r.pin;

endmodule : timer_output_unit

// ==== sim/compact_timer_sva.sv ====
// Port checker for the compact timer
`include "timer_params.svh"
module compact_timer_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output,
  input wire logic period_match_flag
);
  // ----
  // Shadow of the control bytes
  // ----
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [2:0] quiet_r;
  logic wr_go;
  assign wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
  // Quiet counts cycles since the last write, so pipelined updates have landed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      quiet_r <= 3'h0;
    end else begin
      quiet_r <= wr_go ? 3'h0 : (quiet_r == 3'h7 ? 3'h7 : quiet_r + 3'h1);
      if (wr_go && s_axi_awaddr == `OFF_CTRL0) c0_r <= s_axi_wdata[7:0];
      if (wr_go && s_axi_awaddr == `OFF_CTRL1) c1_r <= s_axi_wdata[7:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_en_rise;
    wr_go && s_axi_awaddr == `OFF_CTRL0 && s_axi_wdata[3] && !c0_r[3]
      && c1_r[7:6] == 2'h0;
  endsequence
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_awref; s_axi_bvalid |-> !s_axi_awready; endproperty
  property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_blat; s_wtake |-> ##[1:2] s_axi_bvalid; endproperty
  property p_tmout; c1_r[7:6] == 2'h3 && quiet_r == 3'h7 |-> !timer_output; endproperty
  property p_pwmfix; c1_r[7:5] == 3'h4 && quiet_r == 3'h7
    |-> timer_output == (~(c1_r[4] ^ c1_r[3]) ^ c1_r[2]); endproperty
  property p_enrise; s_en_rise |-> ##[1:4] timer_output == (c1_r[3] ^ c1_r[2]); endproperty
  property p_noper; c1_r[0] && c1_r[7:6] != 2'h2 && quiet_r == 3'h7
    |-> !$rose(period_match_flag); endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  a_rhold: assert property (p_rhold) else $error("read answer not held");
  a_awref: assert property (p_awref) else $error("write taken during response");
  a_arref: assert property (p_arref) else $error("read taken during response");
  a_rlat: assert property (p_rlat) else $error("read answer late");
  a_blat: assert property (p_blat) else $error("write answer late");
  a_tmout: assert property (p_tmout) else $error("pin driven in timer mode");
  a_pwmfix: assert property (p_pwmfix) else $error("fixed pwm level wrong");
  a_enrise: assert property (p_enrise) else $error("initial level missing");
  a_noper: assert property (p_noper) else $error("period flag with clear select");
endmodule : compact_timer_sva
bind compact_timer compact_timer_sva compact_timer_sva_inst (.*);

// ==== sim/pin_partner.sv ====
// Far side model: clock source on the input pin, monitor on the output pin
module pin_partner (
  input wire logic aclk,
  input wire logic timer_output,
  output logic external_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Pin activity
  // ----
  initial external_clock_pin = 1'b0;
  // Phase unrelated to aclk; pulses wide enough for the synchroniser
  task automatic edges(input int n);
    repeat (n) begin
      #130 external_clock_pin = 1'b1;
      #170 external_clock_pin = 1'b0;
    end
    #300;
  endtask : edges
  task automatic highs(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge aclk);
      if (timer_output === 1'b1) h++;
      // An unknown level spoils the count
      else if (timer_output !== 1'b0) h += 4096;
    end
  endtask : highs
endmodule : pin_partner

// ==== sim/compact_timer_test.sv ====
// Self-checking bench for the compact timer
`include "timer_params.svh"
module compact_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, high_clock_tick, sub_clock_tick, external_clock_pin, timer_output;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic compare_match_flag, period_match_flag;
  int failures = 0;
  int checked = 0;
  logic [1:0] last_bresp;
  compact_timer compact_timer_inst (.*);
  pin_partner pin_partner_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic cnt(output logic [9:0] c);
    logic [31:0] h;
    logic [31:0] l;
    logic [1:0] r;
    rd(`OFF_CNT_HI, h, r);
    rd(`OFF_CNT_LO, l, r);
    c = {h[1:0], l[7:0]};
  endtask : cnt
  task automatic run(input logic [7:0] v);
    wr(`OFF_CTRL0, 32'h0);
    wr(`OFF_CTRL0, {24'h0, v});
  endtask : run
  task automatic set_cmp(input logic [9:0] v);
    wr(`OFF_CMP_LO, {24'h0, v[7:0]});
    wr(`OFF_CMP_HI, {30'h0, v[9:8]});
  endtask : set_cmp
  task automatic pulses(input logic sub, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (sub) sub_clock_tick <= 1'b1;
      else high_clock_tick <= 1'b1;
      @(posedge aclk);
      sub_clock_tick <= 1'b0;
      high_clock_tick <= 1'b0;
    end
  endtask : pulses
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] c;
    rd(`OFF_CTRL0, d, r);
    check(d, `CTRL0_RESET);
    rd(`OFF_CTRL1, d, r);
    check(d, `CTRL1_RESET);
    rd(8'h1c, d, r);
    check(r, `RESP_SLVERR);
    wr(8'h1c, 32'h0);
    check(last_bresp, `RESP_SLVERR);
    cnt(c);
    check(c, 10'h000);
  endtask : t_reset
  task automatic t_count();
    logic [9:0] a;
    logic [9:0] b;
    run(8'h18);
    repeat (20) @(posedge aclk);
    wr(`OFF_CTRL0, 32'h98);
    cnt(a);
    check(a != 10'h0, 1'b1);
    wr(`OFF_CNT_HI, 32'h3);
    check(last_bresp, `RESP_OKAY);
    cnt(b);
    check(b, a);
    wr(`OFF_CTRL0, 32'h18);
    wr(`OFF_CTRL0, 32'h98);
    cnt(b);
    check(b > a, 1'b1);
    wr(`OFF_CTRL0, 32'h10);
    cnt(a);
    repeat (20) @(posedge aclk);
    cnt(b);
    check(b, a);
    wr(`OFF_CTRL0, 32'h58);
    repeat (20) @(posedge aclk);
    cnt(a);
    check(a, 10'h000);
  endtask : t_count
  task automatic t_clocks();
    logic [9:0] c;
    run(8'h48);
    pulses(1'b1, 4);
    cnt(c);
    check(c, 10'd4);
    run(8'h28);
    pulses(1'b0, 32);
    cnt(c);
    check(c, 10'd2);
    run(8'h38);
    pulses(1'b0, 64);
    cnt(c);
    check(c, 10'd1);
    run(8'h08);
    repeat (40) @(posedge aclk);
    wr(`OFF_CTRL0, 32'h88);
    cnt(c);
    check(c >= 10'd8 && c <= 10'd13, 1'b1);
    run(8'h68);
    pin_partner_inst.edges(5);
    cnt(c);
    check(c, 10'd5);
    wr(`OFF_CTRL0, 32'h0);
    wr(`OFF_CTRL1, 32'hc8);
    wr(`OFF_CTRL0, 32'h78);
    pin_partner_inst.edges(3);
    cnt(c);
    check(c, 10'd3);
    check(timer_output, 1'b0);
  endtask : t_clocks
  task automatic t_cmp();
    logic [7:0] v [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h0c};
    logic e [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] c;
    int k;
    set_cmp(10'd20);
    rd(`OFF_CMP_HI, d, r);
    check(d, 32'h0);
    rd(`OFF_CMP_LO, d, r);
    check(d, 32'd20);
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_CTRL0, 32'h0);
      wr(`OFF_CTRL1, {24'h0, v[i]});
      wr(`OFF_FLAGS, 32'h3);
      wr(`OFF_CTRL0, 32'h19);
      repeat (4) @(posedge aclk);
      check(timer_output, i != 4);
      k = 0;
      while (compare_match_flag !== 1'b1 && k < 200) begin
        @(posedge aclk);
        k++;
      end
      check(compare_match_flag, 1'b1);
      repeat (5) @(posedge aclk);
      check(timer_output, e[i]);
      repeat (130) @(posedge aclk);
      check(period_match_flag, 1'b1);
    end
    wr(`OFF_CTRL0, 32'h0);
    wr(`OFF_CTRL1, 32'h09);
    wr(`OFF_FLAGS, 32'h3);
    wr(`OFF_CTRL0, 32'h19);
    repeat (200) @(posedge aclk);
    wr(`OFF_CTRL0, 32'h99);
    cnt(c);
    check(c < 10'd20, 1'b1);
    check(compare_match_flag, 1'b1);
    check(period_match_flag, 1'b0);
    set_cmp(10'd0);
    wr(`OFF_CTRL0, 32'h0);
    wr(`OFF_CTRL1, 32'h0);
    wr(`OFF_FLAGS, 32'h3);
    wr(`OFF_CTRL0, 32'h18);
    repeat (1100) @(posedge aclk);
    check(compare_match_flag, 1'b0);
    check(period_match_flag, 1'b1);
  endtask : t_cmp
  task automatic t_pwm();
    logic [7:0] c1 [7] = '{8'ha8, 8'ha8, 8'haa, 8'h88, 8'h98, 8'hac, 8'ha9};
    logic [9:0] cv [7] = '{10'd32, 10'd200, 10'd256, 10'd32, 10'd32, 10'd32, 10'd32};
    int win [7] = '{128, 128, 256, 128, 128, 128, 128};
    int ex [7] = '{32, 128, 128, 0, 128, 96, 32};
    int h;
    for (int i = 0; i < 7; i++) begin
      wr(`OFF_CTRL0, 32'h0);
      wr(`OFF_CTRL1, {24'h0, c1[i]});
      set_cmp(cv[i]);
      wr(`OFF_CTRL0, 32'h19);
      repeat (20) @(posedge aclk);
      pin_partner_inst.highs(win[i], h);
      check(h, ex[i]);
    end
  endtask : t_pwm
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    high_clock_tick = 1'b0;
    sub_clock_tick = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_count();
    t_clocks();
    t_cmp();
    t_pwm();
    final_report();
  end
  // A hang counts as a mismatch
  initial begin
    #2000000;
    failures++;
    final_report();
  end
endmodule : compact_timer_test
